/* File: hw/limit_mon_pkg.sv */
// Purpose: shared constants and types for the limit monitor and event counter
// Assumes: 32-bit classic wishbone register access, signed process values
// Notes: offsets are byte addresses of word registers

package limit_mon_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] UPPER_OFS = 8'h04;
    localparam logic [7:0] LOWER_OFS = 8'h08;
    localparam logic [7:0] HYST_OFS = 8'h0C;
    localparam logic [7:0] THRESH_OFS = 8'h10;
    localparam logic [7:0] STAT_OFS = 8'h14;
    localparam logic [7:0] OVER_CNT_OFS = 8'h18;
    localparam logic [7:0] UNDER_CNT_OFS = 8'h1C;
    localparam logic [7:0] CMD_OFS = 8'h20;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h24;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h28;
    localparam logic [7:0] VALUE_OFS = 8'h2C;

    // ----------------------------------------------------------------
    // control fields
    // ----------------------------------------------------------------
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_OVER_ACT_LSB = 4;
    localparam int CTRL_UNDER_ACT_LSB = 8;
    localparam int CTRL_SEL_LSB = 12;
    localparam int CMD_RESET_ACK_BIT = 0;

    // status bit positions: live alarm, then latched outputs
    localparam int ST_PV_ALARM = 0;
    localparam int ST_LATCH_ALARM = 1;
    localparam int ST_MAINT_DEM = 2;
    localparam int ST_MAINT_REQ = 3;

    // interrupt event positions
    localparam int IRQ_N = 4;
    localparam int IRQ_OVER_EV = 0;
    localparam int IRQ_UNDER_EV = 1;
    localparam int IRQ_LATCH = 2;
    localparam int IRQ_PV_ALARM = 3;

    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    typedef enum logic [1:0] {
        ACT_DISABLED,
        ACT_PV_ALARM,
        ACT_MAINT_DEM,
        ACT_MAINT_REQ
    } action_e;

    // latched counter-triggered outputs
    typedef struct packed {
        logic pv_alarm;
        logic maint_dem;
        logic maint_req;
    } latch_s;

endpackage

/* File: hw/limit_monitor_event_counter.sv */
// Purpose: limit monitoring with overrun/underrun event counting and latched actions
// Assumes: process values synchronous to clk_i, one selected per channel
// Notes: classic wishbone slave, one-cycle ack, level interrupt

`timescale 1ns/1ns

module limit_monitor_event_counter
    import limit_mon_pkg::*;
#(
    parameter int VAL_W = 24,
    parameter int CNT_W = 16,
    parameter int N_SRC = 4,
    parameter int SEL_W = 2
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // process values, packed source by source
    input wire logic [N_SRC*VAL_W-1:0] pv_i,
    // alarm and warning outputs
    output logic pv_alarm_o,
    output logic maint_dem_o,
    output logic maint_req_o,
    output logic irq_o
);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [31:0] ctrl_r, ctrl_nxt;
    logic signed [VAL_W-1:0] upper_r, upper_nxt, lower_r, lower_nxt;
    logic [VAL_W-1:0] hyst_r, hyst_nxt;
    logic [CNT_W-1:0] thresh_r, thresh_nxt;
    logic [CNT_W-1:0] over_cnt_r, over_cnt_nxt, under_cnt_r, under_cnt_nxt;
    logic over_arm_r, over_arm_nxt, under_arm_r, under_arm_nxt;
    latch_s over_lat_r, over_lat_nxt, under_lat_r, under_lat_nxt;
    logic [IRQ_N-1:0] irq_stat_r, irq_stat_nxt, irq_mask_r, irq_mask_nxt;
    logic [31:0] dat_r, dat_nxt;
    logic ack_r, ack_nxt;
    logic pv_alarm_r, pv_alarm_nxt, maint_dem_r, maint_dem_nxt, maint_req_r, maint_req_nxt;
    logic irq_r, irq_nxt;

    // ------------------------------------------------------------
    // value selection and comparisons
    // ------------------------------------------------------------
    logic signed [VAL_W-1:0] pv_src [N_SRC];
    logic signed [VAL_W-1:0] val;
    logic signed [VAL_W:0] lo_minus_h, lo_plus_h;
    logic above, below, over_ev, under_ev, hyst_on, acc, wr;
    logic [SEL_W-1:0] src_sel;
    action_e over_act, under_act;

    genvar g;
    generate
        for (g = 0; g < N_SRC; g++) begin : g_src
            assign pv_src[g] = pv_i[g*VAL_W +: VAL_W];
        end
    endgenerate

    assign src_sel = ctrl_r[CTRL_SEL_LSB +: SEL_W];
    assign val = pv_src[src_sel];
    assign over_act = action_e'(ctrl_r[CTRL_OVER_ACT_LSB +: 2]);
    assign under_act = action_e'(ctrl_r[CTRL_UNDER_ACT_LSB +: 2]);
    // widened by one bit so lower limit +/- hysteresis cannot wrap while hysteresis is at most half the value range
    assign lo_minus_h = {lower_r[VAL_W-1], lower_r} - {1'b0, hyst_r};
    assign lo_plus_h = {lower_r[VAL_W-1], lower_r} + {1'b0, hyst_r};
    assign above = val > upper_r;
    assign below = val < lower_r;
    assign hyst_on = hyst_r != '0;
    assign over_ev = above && over_arm_r;
    assign under_ev = below && under_arm_r;
    assign acc = cyc_i && stb_i && !ack_r;
    assign wr = acc && we_i;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic latch_s fire(input latch_s cur, input action_e act);
        latch_s res;
        res = cur;
        unique case (act)
            ACT_DISABLED: res = cur;
            ACT_PV_ALARM: res.pv_alarm = 1'b1;
            ACT_MAINT_DEM: res.maint_dem = 1'b1;
            ACT_MAINT_REQ: res.maint_req = 1'b1;
        endcase
        return res;
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic rst_ack;
        logic [31:0] wm;
        logic [IRQ_N-1:0] ev;
        rst_ack = 1'b0;
        wm = merge(ZERO_WORD, dat_i, sel_i);
        ev = '0;
        ctrl_nxt = ctrl_r;
        upper_nxt = upper_r;
        lower_nxt = lower_r;
        hyst_nxt = hyst_r;
        thresh_nxt = thresh_r;
        irq_mask_nxt = irq_mask_r;
        over_cnt_nxt = over_cnt_r;
        under_cnt_nxt = under_cnt_r;
        over_arm_nxt = over_arm_r;
        under_arm_nxt = under_arm_r;
        over_lat_nxt = over_lat_r;
        under_lat_nxt = under_lat_r;
        irq_stat_nxt = irq_stat_r;
        ack_nxt = acc;
        dat_nxt = ZERO_WORD;

        if (wr) begin
            unique case (adr_i)
                CTRL_OFS: ctrl_nxt = merge(ctrl_r, dat_i, sel_i);
                UPPER_OFS: upper_nxt = VAL_W'(merge(32'(upper_r), dat_i, sel_i));
                LOWER_OFS: lower_nxt = VAL_W'(merge(32'(lower_r), dat_i, sel_i));
                HYST_OFS: hyst_nxt = VAL_W'(merge(32'(hyst_r), dat_i, sel_i));
                THRESH_OFS: thresh_nxt = CNT_W'(merge(32'(thresh_r), dat_i, sel_i));
                IRQ_MASK_OFS: irq_mask_nxt = IRQ_N'(merge(32'(irq_mask_r), dat_i, sel_i));
                CMD_OFS: rst_ack = wm[CMD_RESET_ACK_BIT];
                IRQ_STAT_OFS: irq_stat_nxt = irq_stat_r & ~IRQ_N'(wm);
                default: ;
            endcase
        end else if (acc) begin
            unique case (adr_i)
                CTRL_OFS: dat_nxt = ctrl_r;
                UPPER_OFS: dat_nxt = 32'(upper_r);
                LOWER_OFS: dat_nxt = 32'(lower_r);
                HYST_OFS: dat_nxt = 32'(hyst_r);
                THRESH_OFS: dat_nxt = 32'(thresh_r);
                STAT_OFS: dat_nxt = {28'h000_0000, maint_req_r, maint_dem_r, pv_alarm_r | over_lat_r.pv_alarm
                                     | under_lat_r.pv_alarm, above | below};
                OVER_CNT_OFS: dat_nxt = 32'(over_cnt_r);
                UNDER_CNT_OFS: dat_nxt = 32'(under_cnt_r);
                IRQ_STAT_OFS: dat_nxt = 32'(irq_stat_r);
                IRQ_MASK_OFS: dat_nxt = 32'(irq_mask_r);
                VALUE_OFS: dat_nxt = 32'(val);
                default: dat_nxt = ZERO_WORD;
            endcase
        end

        // detector re-arm, plain or with hysteresis
        // a concatenation is unsigned, so the widened value is re-signed before comparing
        if (over_ev) begin
            over_arm_nxt = 1'b0;
        end else if (!over_arm_r) begin
            if (hyst_on) begin
                over_arm_nxt = $signed({val[VAL_W-1], val}) < lo_minus_h;
            end else begin
                over_arm_nxt = !above;
            end
        end
        if (under_ev) begin
            under_arm_nxt = 1'b0;
        end else if (!under_arm_r) begin
            if (hyst_on) begin
                under_arm_nxt = $signed({val[VAL_W-1], val}) > lo_plus_h;
            end else begin
                under_arm_nxt = !below;
            end
        end

        // counting goes on whatever the action; counters saturate
        if (over_ev && over_cnt_r != '1) begin
            over_cnt_nxt = over_cnt_r + 1'b1;
            if (over_cnt_nxt == thresh_r) begin
                over_lat_nxt = fire(over_lat_r, over_act);
            end
        end
        if (under_ev && under_cnt_r != '1) begin
            under_cnt_nxt = under_cnt_r + 1'b1;
            if (under_cnt_nxt == thresh_r) begin
                under_lat_nxt = fire(under_lat_r, under_act);
            end
        end

        if (rst_ack) begin
            over_cnt_nxt = '0;
            under_cnt_nxt = '0;
            over_lat_nxt = '0;
            under_lat_nxt = '0;
            over_arm_nxt = 1'b1;
            under_arm_nxt = 1'b1;
        end

        // events set after any clear so a coincident event wins
        pv_alarm_nxt = ctrl_r[CTRL_EN_BIT] && (above || below);
        ev[IRQ_OVER_EV] = over_ev;
        ev[IRQ_UNDER_EV] = under_ev;
        ev[IRQ_LATCH] = (over_lat_nxt & ~over_lat_r) != '0 || (under_lat_nxt & ~under_lat_r) != '0;
        ev[IRQ_PV_ALARM] = pv_alarm_nxt && !pv_alarm_r;
        irq_stat_nxt = irq_stat_nxt | ev;

        maint_dem_nxt = over_lat_nxt.maint_dem | under_lat_nxt.maint_dem;
        maint_req_nxt = over_lat_nxt.maint_req | under_lat_nxt.maint_req;
        irq_nxt = (irq_stat_nxt & irq_mask_nxt) != '0;
    end

    // ------------------------------------------------------------
    // registering
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= CTRL_RST;
            upper_r <= '0;
            lower_r <= '0;
            hyst_r <= '0;
            thresh_r <= '0;
            irq_mask_r <= '0;
            irq_stat_r <= '0;
            over_cnt_r <= '0;
            under_cnt_r <= '0;
            over_arm_r <= 1'b1;
            under_arm_r <= 1'b1;
            over_lat_r <= '0;
            under_lat_r <= '0;
            dat_r <= '0;
            ack_r <= 1'b0;
            pv_alarm_r <= 1'b0;
            maint_dem_r <= 1'b0;
            maint_req_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            upper_r <= upper_nxt;
            lower_r <= lower_nxt;
            hyst_r <= hyst_nxt;
            thresh_r <= thresh_nxt;
            irq_mask_r <= irq_mask_nxt;
            irq_stat_r <= irq_stat_nxt;
            over_cnt_r <= over_cnt_nxt;
            under_cnt_r <= under_cnt_nxt;
            over_arm_r <= over_arm_nxt;
            under_arm_r <= under_arm_nxt;
            over_lat_r <= over_lat_nxt;
            under_lat_r <= under_lat_nxt;
            dat_r <= dat_nxt;
            ack_r <= ack_nxt;
            pv_alarm_r <= pv_alarm_nxt;
            maint_dem_r <= maint_dem_nxt;
            maint_req_r <= maint_req_nxt;
            irq_r <= irq_nxt;
        end
    end

    // latched alarm from the counters merges onto the same alarm pin
    logic pv_out_r;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pv_out_r <= 1'b0;
        end else begin
            pv_out_r <= pv_alarm_nxt | over_lat_nxt.pv_alarm | under_lat_nxt.pv_alarm;
        end
    end

    assign pv_alarm_o = pv_out_r;
    assign maint_dem_o = maint_dem_r;
    assign maint_req_o = maint_req_r;
    assign irq_o = irq_r;
    assign dat_o = dat_r;
    assign ack_o = ack_r;

endmodule

/* File: test/limit_mon_monitor.sv */
// Purpose: port-level checks of the limit monitor bus and latched warning outputs
// Assumes: one clock, synchronous active-high reset
// Notes: bound onto the design at the foot of this file
`timescale 1ns/1ns
module limit_mon_monitor
    import limit_mon_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // latched warnings
    input wire logic maint_dem_o,
    input wire logic maint_req_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // the command takes effect at the edge that takes the request
    logic clr_take;
    assign clr_take = cyc_i && stb_i && we_i && !ack_o && adr_i == CMD_OFS && sel_i[0] && dat_i[CMD_RESET_ACK_BIT];
    property p_ack_pulse; ack_o |=> !ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_ack_prompt; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
    a_ack_prompt: assert property (p_ack_prompt) else $error("request not answered next cycle");
    property p_ack_cause; ack_o |-> $past(cyc_i && stb_i); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_idle_data; !ack_o |-> dat_o == ZERO_WORD; endproperty
    a_idle_data: assert property (p_idle_data) else $error("read data outside ack");
    property p_wr_data; ack_o && we_i |-> dat_o == ZERO_WORD; endproperty
    a_wr_data: assert property (p_wr_data) else $error("data on write ack");
    property p_dem_hold; maint_dem_o && !clr_take |=> maint_dem_o; endproperty
    a_dem_hold: assert property (p_dem_hold) else $error("demanded warning dropped unasked");
    property p_req_fall; $fell(maint_req_o) |-> $past(clr_take); endproperty
    a_req_fall: assert property (p_req_fall) else $error("required warning dropped unasked");
    property p_clr; clr_take |=> !maint_dem_o && !maint_req_o; endproperty
    a_clr: assert property (p_clr) else $error("warnings survive reset-ack");
    property p_rst_quiet; $fell(rst_i) |-> !ack_o && !maint_dem_o && !maint_req_o && dat_o == ZERO_WORD; endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active after reset");
endmodule

bind limit_monitor_event_counter limit_mon_monitor limit_mon_monitor_i (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .maint_dem_o(maint_dem_o), .maint_req_o(maint_req_o)
);

/* File: test/limit_monitor_event_counter_tb_top.sv */
// Purpose: scenario bench for the limit monitor and event counter
// Assumes: limits +100 and -100, source 1 selected
// Notes: values settle three cycles before outputs are judged
`timescale 1ns/1ns
module limit_monitor_event_counter_tb_top
    import limit_mon_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0000_0000;
    logic [31:0] dat_o, q;
    logic ack_o, pv_alarm_o, maint_dem_o, maint_req_o, irq_o;
    logic [95:0] pv_i;
    logic [23:0] val = 24'h00_0000;
    int bad_count = 0, n_compared = 0;
    always #10 clk_i = ~clk_i;

    limit_monitor_event_counter limit_monitor_event_counter_i (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .pv_i(pv_i), .pv_alarm_o(pv_alarm_o),
        .maint_dem_o(maint_dem_o), .maint_req_o(maint_req_o), .irq_o(irq_o));
    pv_source pv_source_i (.clk_i(clk_i), .sel_i(2'h1), .val_i(val), .pv_o(pv_i));

    // ----
    // shared tasks
    // ----
    task automatic close_out;
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmp_bit(input string what, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'h3, w, a, 4'hF, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        q = dat_o;
        {cyc_i, stb_i} <= 2'h0;
        if (n >= 20) begin
            bad_count++;
            close_out();
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        wb(1'b0, a, ZERO_WORD);
        cmp_word(what, exp, q);
    endtask
    task automatic pv(input logic [23:0] v);
        @(posedge clk_i);
        val <= v;
        repeat (3) @(posedge clk_i);
    endtask
    function automatic logic [31:0] ctrl_w(logic en, action_e oa, action_e ua);
        return {18'h0_0000, 2'h1, 2'h0, ua, 2'h0, oa, 3'h0, en};
    endfunction

    // ----
    // scenarios
    // ----
    task automatic sc_limits;
        wb(1'b1, UPPER_OFS, 32'h0000_0064);
        wb(1'b1, LOWER_OFS, 32'h00FF_FF9C);
        wb(1'b1, THRESH_OFS, 32'h0000_0002);
        wb(1'b1, CTRL_OFS, ctrl_w(1'b1, ACT_PV_ALARM, ACT_MAINT_DEM));
        // counting runs while the limits are still being set, so those counts are thrown away
        wb(1'b1, CMD_OFS, 32'h0000_0001);
        pv(24'h00_0096);
        cmp_bit("live alarm", 1'b1, pv_alarm_o);
        pv(24'h00_0064);
        cmp_bit("alarm back in range", 1'b0, pv_alarm_o);
        pv(24'h00_0096);
        pv(24'h00_0000);
        cmp_bit("latched alarm", 1'b1, pv_alarm_o);
        rd(OVER_CNT_OFS, 32'h0000_0002, "over count");
        rd(STAT_OFS, 32'h0000_0002, "status");
    endtask
    task automatic sc_under;
        pv(24'hFF_FF6A);
        pv(24'hFF_FF88);
        pv(24'hFF_FF9C);
        pv(24'hFF_FF6A);
        cmp_bit("demanded warning", 1'b1, maint_dem_o);
        rd(UNDER_CNT_OFS, 32'h0000_0002, "under count");
        wb(1'b1, CMD_OFS, 32'h0000_0001);
        cmp_bit("demanded cleared", 1'b0, maint_dem_o);
        rd(OVER_CNT_OFS, ZERO_WORD, "over count zeroed");
        rd(UNDER_CNT_OFS, 32'h0000_0001, "recount after re-arm");
        pv(24'h00_0000);
    endtask
    task automatic sc_hyst;
        wb(1'b1, HYST_OFS, 32'h0000_0014);
        wb(1'b1, CTRL_OFS, ctrl_w(1'b1, ACT_MAINT_REQ, ACT_PV_ALARM));
        wb(1'b1, CMD_OFS, 32'h0000_0001);
        pv(24'h00_0096);
        pv(24'h00_0032);
        pv(24'h00_0096);
        rd(OVER_CNT_OFS, 32'h0000_0001, "over count held off");
        pv(24'hFF_FF7E);
        pv(24'h00_0096);
        cmp_bit("required warning", 1'b1, maint_req_o);
        rd(OVER_CNT_OFS, 32'h0000_0002, "over count re-armed");
        pv(24'hFF_FF7E);
        pv(24'hFF_FFA6);
        pv(24'hFF_FF7E);
        rd(UNDER_CNT_OFS, 32'h0000_0002, "under count held off");
        pv(24'hFF_FFC4);
        pv(24'hFF_FF7E);
        rd(UNDER_CNT_OFS, 32'h0000_0003, "under count re-armed");
        pv(24'h00_0000);
        cmp_bit("latched alarm from underrun", 1'b1, pv_alarm_o);
    endtask
    task automatic sc_disable;
        wb(1'b1, THRESH_OFS, 32'h0000_0003);
        wb(1'b1, CTRL_OFS, ctrl_w(1'b1, ACT_DISABLED, ACT_DISABLED));
        pv(24'h00_0096);
        pv(24'h00_0000);
        rd(OVER_CNT_OFS, 32'h0000_0003, "count while disabled");
        rd(STAT_OFS, 32'h0000_000A, "nothing new while disabled");
        cmp_bit("required warning kept", 1'b1, maint_req_o);
        wb(1'b1, CMD_OFS, 32'h0000_0001);
        cmp_bit("required warning cleared", 1'b0, maint_req_o);
        cmp_bit("latched alarm cleared", 1'b0, pv_alarm_o);
    endtask
    task automatic sc_irq;
        wb(1'b1, IRQ_STAT_OFS, 32'h0000_000F);
        rd(IRQ_STAT_OFS, ZERO_WORD, "events cleared");
        wb(1'b1, IRQ_MASK_OFS, 32'h0000_0001);
        cmp_bit("irq idle", 1'b0, irq_o);
        pv(24'h00_0096);
        cmp_bit("irq on overrun", 1'b1, irq_o);
        wb(1'b1, IRQ_STAT_OFS, 32'h0000_0001);
        cmp_bit("irq cleared", 1'b0, irq_o);
        pv(24'h00_0000);
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        sc_limits();
        sc_under();
        sc_hyst();
        sc_disable();
        sc_irq();
        close_out();
    end
endmodule

/* File: test/pv_source.sv */
// Purpose: process value source feeding one value on the selected channel
// Assumes: unselected channels carry a pattern that changes every cycle
// Notes: a wrong source pick then sees noise, not a stale copy
`timescale 1ns/1ns
module pv_source #(
    parameter int VAL_W = 24,
    parameter int N_SRC = 4
) (
    input wire logic clk_i,
    input wire logic [1:0] sel_i,
    input wire logic [VAL_W-1:0] val_i,
    output logic [N_SRC*VAL_W-1:0] pv_o
);
    logic [VAL_W-1:0] noise_r = '0;
    always @(posedge clk_i) noise_r <= noise_r + VAL_W'(32'h0012_3457);
    // exactly one value per monitoring channel
    always_comb begin
        for (int k = 0; k < N_SRC; k++) begin
            pv_o[k*VAL_W +: VAL_W] = (k == int'(sel_i)) ? val_i : noise_r ^ VAL_W'(k);
        end
    end
endmodule
